/* ana_defs.svh */
/*
 * Offsets, field positions, reset values and the selector codes of the
 * auto-negotiation advertisement register.
 * Assumes it is included by bare name from the design files.
 */
`ifndef ANA_DEFS_SVH
`define ANA_DEFS_SVH

`define ANA_ADV_OFFSET     5'h04
`define ANA_BIT_NEXT_PAGE  15
`define ANA_BIT_RSVD_RO    14
`define ANA_BIT_RFAULT     13
`define ANA_BIT_RSVD_RW    12
`define ANA_BIT_ASYM_PAUSE 11
`define ANA_BIT_PAUSE      10
`define ANA_BIT_T4         9
`define ANA_BIT_TX_FD      8
`define ANA_BIT_TX_HD      7
`define ANA_BIT_10_FD      6
`define ANA_BIT_10_HD      5
`define ANA_SEL_MSB        4
`define ANA_SEL_LSB        0
`define ANA_SEL_RESET      5'h01
`define ANA_SEL_RSVD_LO    5'h00
`define ANA_SEL_RSVD_HI    5'h1f
`define ANA_RESET_FIXED    16'h0001
`define ANA_WRITE_MASK     16'hbfff
`define ANA_TECH_MASK      16'h01e0

`endif

/* ana_pkg.sv */
/*
 * Types shared by the advertisement register bank and its storage.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ana_pkg;
    typedef logic [15:0] ana_word_type;
    typedef logic [4:0]  ana_addr_type;
    typedef logic [3:0]  ana_tech_type;
endpackage : ana_pkg

/* ana_word_if.sv */
/*
 * Carrier between the register bank and its holding register.
 * Assumes one clock domain shared by both ends.
 */
`timescale 1ns/100ps
interface ana_word_if;
    import ana_pkg::*;
    logic         load;
    ana_word_type load_data;
    ana_word_type held;
    modport bank (output load, output load_data, input held);
    modport store (input load, input load_data, output held);
endinterface : ana_word_if

/* ana_word_store.sv */
/*
 * Holding register for the advertised word; read data from a register.
 * Assumes the straps are stable while rst_b is low and after release.
 */
`timescale 1ns/100ps
`include "ana_defs.svh"
module ana_word_store (
    input  wire logic           sys_clk,
    input  wire logic           rst_b,
    input  wire logic           clk_en,
    input  wire ana_pkg::ana_tech_type strap_tech,
    ana_word_if.store           port
);
    import ana_pkg::*;

    logic seeded;

    // Straps are caught by the first enabled edge after release
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            seeded <= 1'b0;
        end else if (clk_en) begin
            seeded <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            port.held <= `ANA_RESET_FIXED;
        end else if (clk_en) begin
            if (!seeded) begin
                port.held <= `ANA_RESET_FIXED
                    | {7'h00, strap_tech, 5'h00};
            end else if (port.load) begin
                port.held <= port.load_data & `ANA_WRITE_MASK;
            end
        end
    end
endmodule : ana_word_store

/* ana_adv_reg.sv */
/*
 * Auto-negotiation advertisement register bank of a 10/100 transceiver.
 * Assumes a management transport presenting single-cycle read and write
 * strobes with a 5-bit register address, and a negotiation engine that
 * pulses an_start when it starts or restarts.
 */
// What this block does
// - Writable next-page bit 15, reset 0, advertises multi-page ability.
// - Bit 12 writable reserved, write 0; bit 14 read-only zero.
// - Writable asymmetric-pause bit 11, reset 0.
// - Writable pause bit 10, reset 0, advertises full-duplex pause.
// - Writable 100BASE-T4 bit 9, reset 0, advertised though unsupported.
// - Writable bit 8 advertises 100BASE-TX full-duplex.
// - Writable bit 7 advertises 100BASE-TX half-duplex.
// - Writable bit 6 advertises 10BASE-T full-duplex.
// - Writable bit 5 advertises 10BASE-T half-duplex.
// - Technology bits 8:5 reset values come from configuration straps.
`timescale 1ns/100ps
`include "ana_defs.svh"
module ana_adv_reg (
    input  wire logic                  sys_clk,
    input  wire logic                  rst_b,
    input  wire logic                  clk_en,
    input  wire ana_pkg::ana_addr_type reg_addr,
    input  wire logic                  reg_wr,
    input  wire ana_pkg::ana_word_type reg_wdata,
    input  wire logic                  reg_rd,
    output      ana_pkg::ana_word_type reg_rdata,
    output      logic                  reg_rvalid,
    input  wire ana_pkg::ana_tech_type strap_tech,
    input  wire logic                  an_start,
    output      ana_pkg::ana_word_type base_page,
    output      logic                  sel_reserved
);
    import ana_pkg::*;

    ana_word_if link ();

    function automatic logic hit(input ana_addr_type a);
        hit = (a == `ANA_ADV_OFFSET);
    endfunction : hit

    function automatic logic sel_bad(input ana_word_type w);
        logic [4:0] s;
        s = w[`ANA_SEL_MSB:`ANA_SEL_LSB];
        sel_bad = (s == `ANA_SEL_RSVD_LO) || (s == `ANA_SEL_RSVD_HI);
    endfunction : sel_bad

    // Every writable bit is stored straight from the bus word
    assign link.load      = hit(reg_addr) && reg_wr;
    assign link.load_data = reg_wdata;

    ana_word_store u_store (
        .sys_clk    (sys_clk),
        .rst_b      (rst_b),
        .clk_en     (clk_en),
        .strap_tech (strap_tech),
        .port       (link.store)
    );

    // Reads return the word one cycle after the strobe; others read zero
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata  <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else if (clk_en) begin
            reg_rvalid <= reg_rd;
            if (reg_rd && hit(reg_addr)) begin
                reg_rdata <= link.held;
            end else begin
                reg_rdata <= 16'h0000;
            end
        end
    end

    // Word captured for transmission when negotiation (re)starts
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            base_page <= `ANA_RESET_FIXED;
        end else if (clk_en && an_start) begin
            base_page <= link.held;
        end
    end

    // Flags a selector code that software was not meant to load
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sel_reserved <= 1'b0;
        end else if (clk_en) begin
            sel_reserved <= sel_bad(link.held);
        end
    end

    // Steps that the checks below are built from
    sequence wr_take_s;
        clk_en && link.load && u_store.seeded;
    endsequence

    sequence wr_none_s;
        clk_en && !link.load && u_store.seeded;
    endsequence

    sequence seed_s;
        clk_en && !u_store.seeded;
    endsequence

    sequence read_req_s;
        clk_en && reg_rd && hit(reg_addr);
    endsequence

    sequence read_other_s;
        clk_en && reg_rd && !hit(reg_addr);
    endsequence

    sequence read_none_s;
        clk_en && !reg_rd;
    endsequence

    sequence start_s;
        clk_en && an_start;
    endsequence

    // One stored bit follows the bus one edge after the write is taken
    property bit_lands_p(int pos);
        @(posedge sys_clk) disable iff (!rst_b)
        wr_take_s |=> link.held[pos] == $past(reg_wdata[pos]);
    endproperty

    property word_lands_p;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_take_s |=> link.held == ($past(reg_wdata) & `ANA_WRITE_MASK);
    endproperty

    write_store_a: assert property (word_lands_p)
        else $error("write not stored");

    next_page_a: assert property (bit_lands_p(`ANA_BIT_NEXT_PAGE))
        else $error("next page bit not stored");

    rsvd_rw_a: assert property (bit_lands_p(`ANA_BIT_RSVD_RW))
        else $error("bit 12 not stored as written");

    asym_pause_a: assert property (bit_lands_p(`ANA_BIT_ASYM_PAUSE))
        else $error("asymmetric pause bit not stored");

    pause_bit_a: assert property (bit_lands_p(`ANA_BIT_PAUSE))
        else $error("pause bit not stored");

    t4_bit_a: assert property (bit_lands_p(`ANA_BIT_T4))
        else $error("100BASE-T4 bit not stored");

    tx_full_a: assert property (bit_lands_p(`ANA_BIT_TX_FD))
        else $error("100BASE-TX full-duplex bit not stored");

    tx_half_a: assert property (bit_lands_p(`ANA_BIT_TX_HD))
        else $error("100BASE-TX half-duplex bit not stored");

    ten_full_a: assert property (bit_lands_p(`ANA_BIT_10_FD))
        else $error("10BASE-T full-duplex bit not stored");

    ten_half_a: assert property (bit_lands_p(`ANA_BIT_10_HD))
        else $error("10BASE-T half-duplex bit not stored");

    property sel_lands_p;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_take_s |=> link.held[`ANA_SEL_MSB:`ANA_SEL_LSB]
            == $past(reg_wdata[`ANA_SEL_MSB:`ANA_SEL_LSB]);
    endproperty

    sel_write_a: assert property (sel_lands_p)
        else $error("selector not stored");

    property word_holds_p;
        @(posedge sys_clk) disable iff (!rst_b)
        wr_none_s |=> $stable(link.held);
    endproperty

    word_hold_a: assert property (word_holds_p)
        else $error("register changed without a write");

    property rsvd_zero_p;
        @(posedge sys_clk) disable iff (!rst_b)
        !link.held[`ANA_BIT_RSVD_RO] && !reg_rdata[`ANA_BIT_RSVD_RO];
    endproperty

    rsvd_zero_a: assert property (rsvd_zero_p)
        else $error("reserved bit 14 not zero");

    // Read data stands for the cycle after the strobe only
    property read_back_p;
        @(posedge sys_clk) disable iff (!rst_b)
        read_req_s |=> reg_rvalid && reg_rdata == $past(link.held);
    endproperty

    read_back_a: assert property (read_back_p)
        else $error("read data wrong");

    property read_other_p;
        @(posedge sys_clk) disable iff (!rst_b)
        read_other_s |=> reg_rvalid && reg_rdata == 16'h0000;
    endproperty

    read_other_a: assert property (read_other_p)
        else $error("unmapped read not zero");

    property read_none_p;
        @(posedge sys_clk) disable iff (!rst_b)
        read_none_s |=> !reg_rvalid && reg_rdata == 16'h0000;
    endproperty

    read_idle_a: assert property (read_none_p)
        else $error("read data without a strobe");

    // Strap levels seed the technology bits on the first enabled edge
    property strap_seed_p;
        @(posedge sys_clk) disable iff (!rst_b)
        seed_s |=> (link.held & `ANA_TECH_MASK) ==
            {7'h00, $past(strap_tech), 5'h00};
    endproperty

    strap_seed_a: assert property (strap_seed_p)
        else $error("strap defaults not loaded");

    for (genvar t = 0; t < 4; t++) begin : g_strap
        strap_bit_a: assert property (@(posedge sys_clk)
            disable iff (!rst_b)
            seed_s |=> link.held[`ANA_BIT_10_HD + t] == $past(strap_tech[t]))
            else $error("strap bit not loaded");
    end

    property seed_fixed_p;
        @(posedge sys_clk) disable iff (!rst_b)
        seed_s |=> link.held[15:10] == 6'h00
            && link.held[`ANA_SEL_MSB:`ANA_SEL_LSB] == `ANA_SEL_RESET;
    endproperty

    seed_fixed_a: assert property (seed_fixed_p)
        else $error("fixed reset values wrong");

    property seed_once_p;
        @(posedge sys_clk) disable iff (!rst_b)
        u_store.seeded |=> u_store.seeded;
    endproperty

    seed_once_a: assert property (seed_once_p)
        else $error("strap seeding repeated");

    // The base page follows the register only at a negotiation start
    property base_cap_p;
        @(posedge sys_clk) disable iff (!rst_b)
        start_s |=> base_page == $past(link.held);
    endproperty

    base_cap_a: assert property (base_cap_p)
        else $error("base page not captured");

    property base_hold_p;
        @(posedge sys_clk) disable iff (!rst_b)
        !(clk_en && an_start) |=> $stable(base_page);
    endproperty

    base_hold_a: assert property (base_hold_p)
        else $error("base page changed without start");

    property freeze_p;
        @(posedge sys_clk) disable iff (!rst_b)
        !clk_en |=> $stable(link.held) && $stable(reg_rdata)
            && $stable(reg_rvalid) && $stable(base_page)
            && $stable(sel_reserved) && $stable(u_store.seeded);
    endproperty

    freeze_a: assert property (freeze_p)
        else $error("state moved while disabled");

    property rvalid_pulse_p;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> reg_rvalid == $past(reg_rd);
    endproperty

    rvalid_pulse_a: assert property (rvalid_pulse_p)
        else $error("read valid does not follow the strobe");

    // Expected flag comes from the reserved codes themselves
    property sel_flag_p;
        @(posedge sys_clk) disable iff (!rst_b)
        clk_en |=> sel_reserved ==
            ($past(link.held[4:0]) == `ANA_SEL_RSVD_LO
             || $past(link.held[4:0]) == `ANA_SEL_RSVD_HI);
    endproperty

    sel_flag_a: assert property (sel_flag_p)
        else $error("reserved selector flag wrong");

    property sel_low_p;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && link.held[4:0] == `ANA_SEL_RSVD_LO) |=> sel_reserved;
    endproperty

    sel_low_a: assert property (sel_low_p)
        else $error("selector 00000 not flagged");

    property sel_high_p;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && link.held[4:0] == `ANA_SEL_RSVD_HI) |=> sel_reserved;
    endproperty

    sel_high_a: assert property (sel_high_p)
        else $error("selector 11111 not flagged");

    property sel_std_p;
        @(posedge sys_clk) disable iff (!rst_b)
        (clk_en && link.held[4:0] == `ANA_SEL_RESET) |=> !sel_reserved;
    endproperty

    sel_std_a: assert property (sel_std_p)
        else $error("standard selector flagged");
endmodule : ana_adv_reg

/* ana_host_model.sv */
/* Management host model issuing single-cycle register strobes.
   Assumes sys_clk is shared with the register bank. */
`timescale 1ns/100ps
module ana_host_model (
    input  wire logic                  sys_clk,
    output      ana_pkg::ana_addr_type reg_addr,
    output      logic                  reg_wr,
    output      ana_pkg::ana_word_type reg_wdata,
    output      logic                  reg_rd,
    input  wire ana_pkg::ana_word_type reg_rdata,
    input  wire logic                  reg_rvalid
);
    import ana_pkg::*;
    initial begin
        reg_addr = 5'h00;
        reg_wr = 1'b0;
        reg_wdata = 16'h0000;
        reg_rd = 1'b0;
    end
    task automatic wr(input ana_addr_type a, input ana_word_type d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d & 16'hefff;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_wdata = ~reg_wdata;
    endtask : wr
    task automatic rd(input ana_addr_type a, output ana_word_type d,
                      output logic v);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        d = reg_rdata;
        v = reg_rvalid;
        reg_rd = 1'b0;
    endtask : rd
endmodule : ana_host_model

/* tb_top.sv */
/* Self-checking bench for the advertisement register bank.
   Assumes the host model file is compiled first. */
`timescale 1ns/100ps
module tb_top;
    import ana_pkg::*;
    logic         sys_clk, rst_b, clk_en, an_start, wr, rd, rv, sel, v;
    ana_addr_type addr;
    ana_word_type wdata, rdata, base_page, mirror, got, w;
    ana_tech_type strap_tech;
    int           bad_count, cmp_count, seed, i;
    ana_adv_reg i_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en),
        .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
        .reg_rdata(rdata), .reg_rvalid(rv), .strap_tech(strap_tech),
        .an_start(an_start), .base_page(base_page), .sel_reserved(sel));
    ana_host_model i_host (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr),
        .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata), .reg_rvalid(rv));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    function automatic ana_word_type exp_word(input ana_word_type d);
        return d & 16'hafff;
    endfunction : exp_word
    task automatic chk(input string n, input ana_word_type e, g);
        cmp_count++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rdchk(input string n, input ana_word_type e);
        i_host.rd(5'h04, got, v);
        chk(n, e, got);
        chk("rvalid", 16'h0001, {15'h0000, v});
    endtask : rdchk
    task automatic do_reset;
        strap_tech = 4'($random(seed));
        rst_b = 1'b0;
        repeat (5) @(negedge sys_clk);
        rst_b = 1'b1;
        repeat (2) @(negedge sys_clk);
        mirror = 16'h0001 | {7'h00, strap_tech, 5'h00};
    endtask : do_reset
    task complete_run;
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    initial begin
        #2_000_000;
        bad_count++;
        complete_run();
    end
    initial begin
        seed = 18;
        clk_en = 1'b1;
        an_start = 1'b0;
        do_reset();
        chk("base_page", 16'h0001, base_page);
        rdchk("reset", mirror);
        for (i = 0; i < 16; i++) begin
            w = (i == 0) ? 16'hffe1 : 16'($random(seed));
            w[4:0] = 5'h01;
            i_host.wr(5'h04, w);
            mirror = exp_word(w);
            rdchk("rw", mirror);
        end
        $display("test write_read done");
        i_host.wr(5'h05, 16'h1234);
        i_host.rd(5'h05, got, v);
        chk("unmapped", 16'h0000, got);
        chk("unmapped_rvalid", 16'h0001, {15'h0000, v});
        clk_en = 1'b0;
        i_host.wr(5'h04, 16'h0021);
        clk_en = 1'b1;
        rdchk("kept", mirror);
        @(negedge sys_clk) an_start = 1'b1;
        @(negedge sys_clk) an_start = 1'b0;
        chk("base_page", mirror, base_page);
        for (i = 0; i < 3; i++) begin
            w = (i == 0) ? 16'h0000 : (i == 1) ? 16'h001f : 16'h0001;
            i_host.wr(5'h04, w);
            @(negedge sys_clk);
            chk("sel_reserved", {15'h0000, i != 2}, {15'h0000, sel});
        end
        chk("base_page", mirror, base_page);
        $display("test selector done");
        do_reset();
        rdchk("rereset", mirror);
        $display("test second_reset done");
        complete_run();
    end
endmodule : tb_top
